// ### shared/tbd_defines.svh
`ifndef TBD_DEFINES_SVH
`define TBD_DEFINES_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define TBD_IDX_CTRL       8'h36
`define TBD_IDX_STATUS     8'h37
`define TBD_IDX_MASK       8'h38

// ==========================================================================
// control register fields
`define TBD_CTRL_TONE_EN   7
`define TBD_CTRL_TONE_HI   6
`define TBD_CTRL_TONE_LO   5
`define TBD_CTRL_LOWCLK    4
`define TBD_CTRL_TICK_EN   3
`define TBD_CTRL_TICK_HI   2
`define TBD_CTRL_TICK_LO   0

// ==========================================================================
// status and mask fields
`define TBD_ST_TICK        0
`define TBD_ST_BADRATE     1
`define TBD_ST_WIDTH       2

// ==========================================================================
// reset values
`define TBD_CTRL_RST       8'h00
`define TBD_STATUS_RST     2'h0
`define TBD_MASK_RST       2'h0

// ==========================================================================
// divider tap widths and synchroniser depth
`define TBD_FC_TAPS        24
`define TBD_FS_TAPS        16
`define TBD_SYNC_STAGES    2

`endif

// ### shared/tbd_pkg.sv
package tbd_pkg;

  // ========================================================================
  // operating modes of the clock system
  typedef enum logic [1:0] {
    FAST_RUN,
    FAST_HALT,
    LOW_CLOCK_RUN,
    LOW_CLOCK_HALT
  } tbd_mode_t;

endpackage

// ### rtl/tbd_sync.sv
`timescale 1ns/1ps
module tbd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule // tbd_sync

// ### rtl/tbd_fall.sv
`timescale 1ns/1ps
module tbd_fall (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // level in, gated edge out
  input  wire logic lvl_i,
  input  wire logic en_i,
  output logic      fall_o
);

  logic prev_ff;

  // history runs even while gated, so the first edge after enabling counts
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= lvl_i;
    end
  end

  assign fall_o = en_i & prev_ff & ~lvl_i;

endmodule // tbd_fall

// ### rtl/tbd_time_base.sv
`timescale 1ns/1ps
`include "tbd_defines.svh"
module tbd_time_base (
  // clock and reset
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      SRST_I,
  // apb slave
  input  wire logic                      PSEL_I,
  input  wire logic                      PENABLE_I,
  input  wire logic                      PWRITE_I,
  input  wire logic [11:0]               PADDR_I,
  input  wire logic [31:0]               PWDATA_I,
  output logic      [31:0]               PRDATA_O,
  output logic                           PREADY_O,
  output logic                           PSLVERR_O,
  // divider chain taps, bit n is clock/2^n
  input  wire logic [`TBD_FC_TAPS-1:0]   FC_TAP_I,
  input  wire logic [`TBD_FS_TAPS-1:0]   FS_TAP_I,
  // operating mode from the clock system
  input  wire logic [1:0]                MODE_I,
  // events and pins
  output logic                           TICK_PULSE_O,
  output logic                           IRQ_O,
  output logic                           TONE_N_O
);

  // ========================================================================
  // register state
  logic [7:0]                ctrl_ff;
  logic [`TBD_ST_WIDTH-1:0]  status_ff;
  logic [`TBD_ST_WIDTH-1:0]  mask_ff;
  logic [`TBD_ST_WIDTH-1:0]  nxt_status;
  logic                      bad_prev_ff;

  // apb answer registers
  logic [31:0]               prdata_ff;
  logic                      pready_ff;
  logic                      pslverr_ff;
  logic [31:0]               nxt_prdata;

  // output registers
  logic                      tick_pulse_ff;
  logic                      irq_ff;
  logic                      tone_n_ff;

  // ========================================================================
  // control fields
  wire                       tone_out_enable;
  wire [1:0]                 tone_rate_select;
  wire                       divider_low_clock_select;
  wire                       tick_enable;
  wire [2:0]                 tick_rate_select;

  assign tone_out_enable          = ctrl_ff[`TBD_CTRL_TONE_EN];
  assign tone_rate_select         = ctrl_ff[`TBD_CTRL_TONE_HI:
                                            `TBD_CTRL_TONE_LO];
  assign divider_low_clock_select = ctrl_ff[`TBD_CTRL_LOWCLK];
  assign tick_enable              = ctrl_ff[`TBD_CTRL_TICK_EN];
  assign tick_rate_select         = ctrl_ff[`TBD_CTRL_TICK_HI:
                                            `TBD_CTRL_TICK_LO];

  // ========================================================================
  // divider taps into this clock domain
  // taps run on fc or fs, which are unrelated to the system clock
  logic [`TBD_FC_TAPS-1:0]   fc_tap;
  logic [`TBD_FS_TAPS-1:0]   fs_tap;

  tbd_sync #(
    .WIDTH (`TBD_FC_TAPS)
  ) u_fc_sync (
    .clk_i   (CLK_SYS_I),
    .srst_i  (SRST_I),
    .async_i (FC_TAP_I),
    .sync_o  (fc_tap)
  );

  tbd_sync #(
    .WIDTH (`TBD_FS_TAPS)
  ) u_fs_sync (
    .clk_i   (CLK_SYS_I),
    .srst_i  (SRST_I),
    .async_i (FS_TAP_I),
    .sync_o  (fs_tap)
  );

  // ========================================================================
  // mode decode
  tbd_pkg::tbd_mode_t        mode;
  wire                       low_clock_mode;
  wire                       use_fs;

  assign mode           = tbd_pkg::tbd_mode_t'(MODE_I);
  assign low_clock_mode = (mode == tbd_pkg::LOW_CLOCK_RUN) ||
                          (mode == tbd_pkg::LOW_CLOCK_HALT);
  assign use_fs         = divider_low_clock_select | low_clock_mode;

  // ========================================================================
  // tick tap selection
  wire [7:0]                 tick_fc_row;
  wire [7:0]                 tick_fs_row;
  wire                       tick_fc_tap;
  wire                       tick_fs_tap;
  wire                       tick_rate_bad;
  wire                       tick_tap;

  assign tick_fc_row = {fc_tap[9],  fc_tap[11], fc_tap[12], fc_tap[13],
                        fc_tap[14], fc_tap[16], fc_tap[21], fc_tap[23]};
  assign tick_fs_row = {fs_tap[1],  fs_tap[3],  fs_tap[4],  fs_tap[5],
                        fs_tap[6],  fs_tap[8],  fs_tap[13], fs_tap[15]};
  assign tick_fc_tap = tick_fc_row[tick_rate_select];
  assign tick_fs_tap = tick_fs_row[tick_rate_select];
  // codes above 001 have no tap in low-clock modes: hold the line quiet
  assign tick_rate_bad = low_clock_mode & (tick_rate_select > 3'h1);
  assign tick_tap    = tick_rate_bad ? 1'b1 :
                       (use_fs ? tick_fs_tap : tick_fc_tap);

  // ========================================================================
  // tone tap selection
  wire [3:0]                 tone_fc_row;
  wire [3:0]                 tone_fs_row;
  wire                       tone_tap;

  assign tone_fc_row = {fc_tap[10], fc_tap[11], fc_tap[12], fc_tap[13]};
  assign tone_fs_row = {fs_tap[2],  fs_tap[3],  fs_tap[4],  fs_tap[5]};
  assign tone_tap    = use_fs ? tone_fs_row[tone_rate_select] :
                                tone_fc_row[tone_rate_select];

  // ========================================================================
  // tick edge detection
  // the chain is never cleared here, so the first tick may come early
  wire                       tick_fall;

  tbd_fall u_tick_fall (
    .clk_i  (CLK_SYS_I),
    .srst_i (SRST_I),
    .lvl_i  (tick_tap),
    .en_i   (tick_enable),
    .fall_o (tick_fall)
  );

  // ========================================================================
  // apb decode
  wire                       apb_access;
  wire                       apb_done;
  wire                       apb_wr;
  wire                       apb_rd;
  wire [11:0]                addr_ctrl;
  wire [11:0]                addr_status;
  wire [11:0]                addr_mask;
  wire                       hit_ctrl;
  wire                       hit_status;
  wire                       hit_mask;
  wire                       hit_any;

  assign addr_ctrl   = {2'h0, `TBD_IDX_CTRL,   2'h0};
  assign addr_status = {2'h0, `TBD_IDX_STATUS, 2'h0};
  assign addr_mask   = {2'h0, `TBD_IDX_MASK,   2'h0};

  assign apb_access  = PSEL_I & PENABLE_I;
  // one wait state: the answer is raised in the second access cycle
  assign apb_done    = apb_access & pready_ff;
  assign apb_wr      = apb_done & PWRITE_I;
  assign apb_rd      = apb_access & ~pready_ff & ~PWRITE_I;

  assign hit_ctrl    = (PADDR_I == addr_ctrl);
  assign hit_status  = (PADDR_I == addr_status);
  assign hit_mask    = (PADDR_I == addr_mask);
  assign hit_any     = hit_ctrl | hit_status | hit_mask;

  // ========================================================================
  // read data
  assign nxt_prdata = hit_ctrl   ? {24'h0, ctrl_ff} :
                      hit_status ? {30'h0, status_ff} :
                      hit_mask   ? {30'h0, mask_ff} :
                                   32'h0;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= apb_access & ~pready_ff;
      pslverr_ff <= apb_access & ~pready_ff & ~hit_any;
      prdata_ff  <= apb_rd ? nxt_prdata : 32'h0;
    end
  end

  // ========================================================================
  // control register
  // plain store: the rate fields and enables may change in one write
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ctrl_ff <= `TBD_CTRL_RST;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_ff <= PWDATA_I[7:0];
    end
  end

  // ========================================================================
  // mask register
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      mask_ff <= `TBD_MASK_RST;
    end else if (apb_wr && hit_mask) begin
      mask_ff <= PWDATA_I[`TBD_ST_WIDTH-1:0];
    end
  end

  // ========================================================================
  // status register, write one to clear, a new event beats the clear
  wire [`TBD_ST_WIDTH-1:0]   st_set;
  wire [`TBD_ST_WIDTH-1:0]   st_clr;
  wire                       bad_rise;

  // flag the bad rate once, when it first appears with ticking on
  assign bad_rise = tick_enable & tick_rate_bad & ~bad_prev_ff;

  assign st_set[`TBD_ST_TICK]    = tick_fall;
  assign st_set[`TBD_ST_BADRATE] = bad_rise;
  assign st_clr = (apb_wr && hit_status) ?
                  PWDATA_I[`TBD_ST_WIDTH-1:0] : '0;
  assign nxt_status = (status_ff & ~st_clr) | st_set;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      status_ff   <= `TBD_STATUS_RST;
      bad_prev_ff <= 1'b0;
    end else begin
      status_ff   <= nxt_status;
      bad_prev_ff <= tick_enable & tick_rate_bad;
    end
  end

  // ========================================================================
  // outputs
  wire                       nxt_irq;
  wire                       nxt_tone_n;

  // level from the next status so the line follows the flag without a gap
  assign nxt_irq    = |(nxt_status & mask_ff);
  // idle level is high, so a disabled buzzer sees no drive
  assign nxt_tone_n = tone_out_enable ? tone_tap : 1'b1;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      tick_pulse_ff <= 1'b0;
      irq_ff        <= 1'b0;
      tone_n_ff     <= 1'b1;
    end else begin
      tick_pulse_ff <= tick_fall;
      irq_ff        <= nxt_irq;
      tone_n_ff     <= nxt_tone_n;
    end
  end

  assign PRDATA_O     = prdata_ff;
  assign PREADY_O     = pready_ff;
  assign PSLVERR_O    = pslverr_ff;
  assign TICK_PULSE_O = tick_pulse_ff;
  assign IRQ_O        = irq_ff;
  assign TONE_N_O     = tone_n_ff;

endmodule // tbd_time_base

// ### verif/tbd_time_base_monitor.sv
`timescale 1ns/1ps
`include "tbd_defines.svh"
module tbd_time_base_monitor (
  // clock and reset
  input wire logic                    CLK_SYS_I,
  input wire logic                    SRST_I,
  // apb
  input wire logic                    PSEL_I,
  input wire logic                    PENABLE_I,
  input wire logic                    PWRITE_I,
  input wire logic [11:0]             PADDR_I,
  input wire logic [31:0]             PRDATA_O,
  input wire logic                    PREADY_O,
  input wire logic                    PSLVERR_O,
  // taps and events
  input wire logic [`TBD_FC_TAPS-1:0] FC_TAP_I,
  input wire logic [`TBD_FS_TAPS-1:0] FS_TAP_I,
  input wire logic                    TICK_PULSE_O
);
  // ========================================================================
  // helpers
  logic [`TBD_FC_TAPS-1:0] fc_ff;
  logic [`TBD_FS_TAPS-1:0] fs_ff;
  logic [7:0]              fell_ff;
  logic                    hit;
  assign hit = PADDR_I == {2'h0, `TBD_IDX_CTRL, 2'h0} ||
               PADDR_I == {2'h0, `TBD_IDX_STATUS, 2'h0} ||
               PADDR_I == {2'h0, `TBD_IDX_MASK, 2'h0};
  // any tap fall counts: selection is not visible here
  always_ff @(posedge CLK_SYS_I) begin
    fc_ff   <= FC_TAP_I;
    fs_ff   <= FS_TAP_I;
    fell_ff <= {fell_ff[6:0], |(fc_ff & ~FC_TAP_I) | |(fs_ff & ~FS_TAP_I)};
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  // ========================================================================
  // properties
  property p_rdy_lat; PSEL_I && !PENABLE_I |-> ##2 PREADY_O; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("ready late");
  property p_rdy_src; PREADY_O |-> $past(PSEL_I && PENABLE_I); endproperty
  a_rdy_src: assert property (p_rdy_src) else $error("stray ready");
  property p_rdy_one; PREADY_O |=> !PREADY_O; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("long ready");
  property p_err_rdy; PSLVERR_O |-> PREADY_O; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("stray error");
  property p_err_map; PREADY_O |-> PSLVERR_O == !hit; endproperty
  a_err_map: assert property (p_err_map) else $error("bad error");
  property p_rd_idle;
    !(PREADY_O && !PWRITE_I) |-> PRDATA_O == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("data idle");
  property p_rd_hi; PRDATA_O[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper bits set");
  property p_tick_src; TICK_PULSE_O |-> |fell_ff[6:1]; endproperty
  a_tick_src: assert property (p_tick_src) else $error("tick no edge");
endmodule // tbd_time_base_monitor

bind tbd_time_base tbd_time_base_monitor u_mon (
  .CLK_SYS_I, .SRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PRDATA_O, .PREADY_O, .PSLVERR_O, .FC_TAP_I, .FS_TAP_I, .TICK_PULSE_O
);

// ### verif/tbd_time_base_test.sv
`timescale 1ns/1ps
`include "tbd_defines.svh"
module tbd_time_base_test;
  localparam int TK [16] = '{23,21,16,14,13,12,11,9,15,13,8,6,5,4,3,1};
  localparam int TN [8] = '{13,12,11,10,5,4,3,2};
  localparam logic [11:0] ACT = {2'h0, `TBD_IDX_CTRL, 2'h0};
  localparam logic [11:0] AST = {2'h0, `TBD_IDX_STATUS, 2'h0};
  localparam logic [11:0] AMK = {2'h0, `TBD_IDX_MASK, 2'h0};
  logic        clk, rst, psel, pen, pwr, pready, perr, tick, irq, tone_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rs;
  logic [23:0] fc, fcm;
  logic [15:0] fs, fsm;
  logic [1:0]  mode;
  logic [7:0]  ct;
  logic [32:0] q [$];
  int          fails, checked, m, c, ticks, nt;

  tbd_time_base dut (
    .CLK_SYS_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .FC_TAP_I(fc), .FS_TAP_I(fs), .MODE_I(mode),
    .TICK_PULSE_O(tick), .IRQ_O(irq), .TONE_N_O(tone_n)
  );

  // ========================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %0t got %h want %h", $time, s, e);
    end
  endtask
  // holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    q.push_back(e);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic tap(input logic [23:0] f, input logic [15:0] s);
    @(posedge clk);
    fc <= f;
    fs <= s;
    cyc(6);
  endtask
  task automatic pick(input int b, input bit f);
    fcm = '1;
    fsm = '1;
    if (f) fsm[b] = 1'b0;
    else fcm[b] = 1'b0;
  endtask
  task automatic ci(input logic e);
    cyc(2);
    chk(irq, e);
  endtask

  // ========================================================================
  // scoreboard and clocks
  always @(posedge clk) begin
    if (pready === 1'b1) chk({perr, prdata}, q.pop_front());
    if (tick === 1'b1) ticks++;
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    cyc(20000);
    fails++;
    report_and_stop();
  end

  // ========================================================================
  // sequence
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata, mode} = {1'b1, 49'h0};
    {ticks, nt} = 64'h0;
    {fc, fs, fails, checked, rs} = {40'hFF_FFFF_FFFF, 64'h0, 32'h443F};
    cyc(16);
    rst <= 1'b0;
    cyc(3);
    chk(tone_n, 1'b1);
    chk(irq, 1'b0);
    rd(ACT, 32'h0);
    rd(AST, 32'h0);
    rd(AMK, 32'h0);
    apb(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
    for (m = 0; m < 3; m++) begin
      for (c = 0; c < 8; c++) begin
        if (m == 2 && c > 1) continue;
        ct = {3'h0, m == 1, 1'b1, c[2:0]};
        rs = xs(rs);
        mode <= (m == 2) ? tbd_pkg::LOW_CLOCK_RUN :
                rs[0] ? tbd_pkg::FAST_HALT : tbd_pkg::FAST_RUN;
        pick(TK[(m > 0) * 8 + c], m > 0);
        // a fall while disabled must not count
        tap(fcm, fsm);
        tap('1, '1);
        wr(ACT, {rs[31:8], ct});
        rd(ACT, {24'h0, ct});
        tap(~fcm, ~fsm);
        tap('1, '1);
        rd(AST, 32'h0);
        repeat (2) begin
          tap(fcm, fsm);
          nt++;
          chk(ticks, nt);
          rd(AST, 32'h1);
          wr(AST, 32'h1);
          tap('1, '1);
        end
        wr(ACT, {24'h0, ct & 8'hF7});
      end
    end
    mode <= tbd_pkg::FAST_RUN;
    wr(ACT, 32'h8);
    wr(AMK, 32'h1);
    rd(AMK, 32'h1);
    pick(23, 1'b0);
    tap(fcm, fsm);
    nt++;
    ci(1'b1);
    wr(AMK, 32'h0);
    ci(1'b0);
    wr(AMK, 32'h1);
    ci(1'b1);
    wr(AST, 32'h1);
    ci(1'b0);
    wr(ACT, 32'h0);
    // code 010 has no tap in low-clock modes: flagged once, never ticks
    mode <= tbd_pkg::LOW_CLOCK_RUN;
    wr(ACT, 32'h2);
    wr(ACT, 32'hA);
    pick(8, 1'b1);
    tap(fcm, fsm);
    rd(AST, 32'h2);
    wr(AST, 32'h2);
    rd(AST, 32'h0);
    chk(ticks, nt);
    chk(irq, 1'b0);
    wr(ACT, 32'h2);
    for (m = 0; m < 12; m++) begin
      ct = {1'b0, m[1:0], m / 4 == 1, 4'h0};
      mode <= (m > 7) ? tbd_pkg::LOW_CLOCK_HALT : tbd_pkg::FAST_RUN;
      pick(TN[(m > 3) * 4 + m % 4], m > 3);
      wr(ACT, {24'h0, ct});
      tap(fcm, fsm);
      chk(tone_n, 1'b1);
      wr(ACT, {24'h0, ct | 8'h80});
      cyc(4);
      chk(tone_n, 1'b0);
      tap(~fcm, ~fsm);
      chk(tone_n, 1'b1);
      tap(fcm, fsm);
      wr(ACT, {24'h0, ct});
      cyc(4);
      chk(tone_n, 1'b1);
    end
    report_and_stop();
  end
endmodule // tbd_time_base_test
